// ### shared/sevr_params.svh
`ifndef SEVR_PARAMS_SVH
`define SEVR_PARAMS_SVH
// standard event status bit positions
`define SEVR_BIT_PON   7
`define SEVR_BIT_URQ   6
`define SEVR_BIT_CME   5
`define SEVR_BIT_EXE   4
`define SEVR_BIT_DDE   3
`define SEVR_BIT_QYE   2
`define SEVR_BIT_RQC   1
`define SEVR_BIT_OPC   0
// status byte bit positions
`define SEVR_SBY_XSUM2 7
`define SEVR_SBY_MSS   6
`define SEVR_SBY_ESB   5
`define SEVR_SBY_MAV   4
`define SEVR_SBY_XSUM1 3
`define SEVR_SBY_ERR   2
// readable bits of the event status register (bits 6 and 1 unused)
`define SEVR_ESR_USED  8'hBD
// readable bits of the service request enable mask
`define SEVR_SRE_USED  8'hBC
// reset values
`define SEVR_RST_MASK  8'h00
`define SEVR_RST_ESR   8'h00
`endif

// ### shared/sevr_pkg.sv
package sevr_pkg;
  // register selector for writes and queries
  typedef enum logic [1:0] {
    SEVR_SEL_ESE,
    SEVR_SEL_ESR,
    SEVR_SEL_SRE,
    SEVR_SEL_SBY
  } sevr_sel_e;

  // one command from the parser
  typedef struct packed {
    logic            wr;
    logic            rd;
    logic            clr;
    logic            opc;
    sevr_sel_e       sel;
    logic [7:0]      wdata;
  } sevr_cmd_s;

  // device event pulses
  typedef struct packed {
    logic            pon;
    logic            urq;
    logic            cme;
    logic            exe;
    logic            dde;
    logic            qye;
    logic            rqc;
  } sevr_evt_s;
endpackage

// ### verilog/sevr_opc_track.sv
`timescale 1ns/100ps
`include "sevr_params.svh"
// ********************************
// operation-complete tracker
// ********************************
module sevr_opc_track
  import sevr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic arm,
  input  wire logic busy,
  output logic      done
);
  logic armed;

  // waits for pending work to drain after arming
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if ((arm || armed) && !busy) begin
        armed <= 1'b0;
        done  <= 1'b1;
      end else if (arm) begin
        armed <= 1'b1;
      end
    end
  end
endmodule // sevr_opc_track

// ### verilog/sevr_status.sv
`timescale 1ns/100ps
`include "sevr_params.svh"
// Overview of operation
// - the clear-status command zeroes the event status register, keeping events that arrive in the same cycle.
// - the clear-status command zeroes the event summary and error bits of the byte.
// - the clear-status command drops any pending error state unless an error arrives in the same cycle.
// - the event enable mask is written 0..255 and read back as kept.
// - the event enable mask is zero after power-on.
// - an enabled, set event raises status byte bit 5.
// - enable mask bits 7..0 map to the eight standard events.
// - the event status reads 0..255 with bits 6 and 1 always zero.
// - the service request mask is written 0..255 and read back.
// - the service request mask is zero at power-on, unused bits 0.
// - service mask bit 2 lets the error bit raise the master bit.
// - a status byte query returns its present 8-bit value.
// - after the completion command, finished work sets bit 0.
module sevr_status
  import sevr_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rstn,
  input  wire sevr_cmd_s cmd,
  input  wire sevr_evt_s evt,
  input  wire logic      busy,
  input  wire logic      err_evt,
  input  wire logic      mav,
  input  wire logic      first_extra_event_summary,
  input  wire logic      second_extra_event_summary,
  output logic [7:0]     rdata,
  output logic           rvalid,
  output logic [7:0]     status_summary_byte,
  output logic           srq
);
  // ********************************
  // storage
  // ********************************
  logic [7:0] event_enable_mask;
  logic [7:0] standard_event_status;
  logic [7:0] service_request_enable_mask;
  logic       err_pending;
  logic       opc_done;
  logic [7:0] evt_vec;
  logic [7:0] next_sby;
  logic       next_esb;
  logic       pon_seen;

  // ********************************
  // completion tracking
  // ********************************
  sevr_opc_track u_opc (
    .clk  (clk),
    .rstn (rstn),
    .arm  (cmd.opc),
    .busy (busy),
    .done (opc_done)
  );

  // event vector in register order
  always_comb begin
    evt_vec = 8'h00;
    evt_vec[`SEVR_BIT_PON] = evt.pon || !pon_seen;
    evt_vec[`SEVR_BIT_CME] = evt.cme;
    evt_vec[`SEVR_BIT_EXE] = evt.exe;
    evt_vec[`SEVR_BIT_DDE] = evt.dde;
    evt_vec[`SEVR_BIT_QYE] = evt.qye;
    evt_vec[`SEVR_BIT_OPC] = opc_done;
  end

  // power-on event raised once after reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pon_seen <= 1'b0;
    end else begin
      pon_seen <= 1'b1;
    end
  end

  // ********************************
  // event status register
  // ********************************
  // set wins over clear so no event is lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standard_event_status <= `SEVR_RST_ESR;
    end else if (cmd.clr) begin
      standard_event_status <= evt_vec & `SEVR_ESR_USED;
    end else if (cmd.rd && cmd.sel == SEVR_SEL_ESR) begin
      // reading the event register clears it, new events kept
      standard_event_status <= evt_vec & `SEVR_ESR_USED;
    end else begin
      standard_event_status <= (standard_event_status | evt_vec)
                               & `SEVR_ESR_USED;
    end
  end

  // ********************************
  // error state
  // ********************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_pending <= 1'b0;
    end else if (err_evt) begin
      err_pending <= 1'b1;
    end else if (cmd.clr) begin
      err_pending <= 1'b0;
    end
  end

  // ********************************
  // masks
  // ********************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_enable_mask <= `SEVR_RST_MASK;
    end else if (cmd.wr && cmd.sel == SEVR_SEL_ESE) begin
      event_enable_mask <= cmd.wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      service_request_enable_mask <= `SEVR_RST_MASK;
    end else if (cmd.wr && cmd.sel == SEVR_SEL_SRE) begin
      // unused bits dropped so a query shows them as zero
      service_request_enable_mask <= cmd.wdata & `SEVR_SRE_USED;
    end
  end

  // ********************************
  // status byte
  // ********************************
  always_comb begin
    next_esb = |(standard_event_status & event_enable_mask);
    if (cmd.clr) begin
      next_esb = 1'b0;
    end
    next_sby = 8'h00;
    next_sby[`SEVR_SBY_XSUM2] = second_extra_event_summary;
    next_sby[`SEVR_SBY_ESB]   = next_esb;
    next_sby[`SEVR_SBY_MAV]   = mav;
    next_sby[`SEVR_SBY_XSUM1] = first_extra_event_summary;
    next_sby[`SEVR_SBY_ERR]   = err_pending && !cmd.clr;
    // master bit from enabled bits, error via mask bit 2
    next_sby[`SEVR_SBY_MSS] =
      |(next_sby & service_request_enable_mask);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_summary_byte <= 8'h00;
      srq                 <= 1'b0;
    end else begin
      status_summary_byte <= next_sby;
      srq                 <= next_sby[`SEVR_SBY_MSS];
    end
  end

  // ********************************
  // query answers, one cycle after request
  // ********************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= cmd.rd;
      if (cmd.rd) begin
        unique case (cmd.sel)
          SEVR_SEL_ESE: rdata <= event_enable_mask;
          SEVR_SEL_ESR: rdata <= standard_event_status;
          SEVR_SEL_SRE: rdata <= service_request_enable_mask;
          SEVR_SEL_SBY: rdata <= status_summary_byte;
        endcase
      end
    end
  end
endmodule // sevr_status

// ### testbench/sevr_ctrl_model.sv
`timescale 1ns/100ps
// ****
// remote controller model
// ****
module sevr_ctrl_model
  import sevr_pkg::*;
(
  input  wire logic clk,
  output sevr_cmd_s cmd
);
  initial cmd = '0;
  // one command, held across exactly one sampling edge
  task automatic send(input logic [3:0] k, input sevr_sel_e s,
                      input logic [7:0] d);
    @(posedge clk) #1;
    cmd = {k, s, d};
    @(posedge clk) #1;
    cmd = '0;
  endtask
endmodule // sevr_ctrl_model

// ### testbench/sevr_status_chk.sv
`timescale 1ns/100ps
// ****
// port checker
// ****
module sevr_status_chk
  import sevr_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire sevr_cmd_s  cmd,
  input wire logic       err_evt,
  input wire logic       mav,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic [7:0] status_summary_byte,
  input wire logic       srq
);
  // one domain, so clock and reset are shared
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_ANSWER: assert property (cmd.rd |=> rvalid)
    else $error("no answer");
  AST_NO_EXTRA: assert property (!cmd.rd |=> !rvalid)
    else $error("stray answer");
  AST_HOLD: assert property (!rvalid |-> $stable(rdata))
    else $error("data moved");
  AST_SRE_ZERO: assert property (
    rvalid && $past(cmd.sel) == SEVR_SEL_SRE |-> (rdata & 8'h43) == 8'h00)
    else $error("unused mask bit set");
  AST_ESR_ZERO: assert property (
    rvalid && $past(cmd.sel) == SEVR_SEL_ESR |-> (rdata & 8'h42) == 8'h00)
    else $error("unused event bit set");
  AST_MSS: assert property (srq == status_summary_byte[6])
    else $error("master bit differs");
  AST_MAV: assert property (
    $past(rstn) |-> status_summary_byte[4] == $past(mav))
    else $error("message bit late");
  AST_CLR_ERR: assert property (
    cmd.clr && !err_evt ##1 !err_evt |=> !status_summary_byte[2])
    else $error("error kept");
  AST_CLR_ESB: assert property (
    cmd.clr |=> !status_summary_byte[5])
    else $error("event summary kept");
  AST_MSS_SRC: assert property (
    srq |-> (status_summary_byte & 8'hbc) != 8'h00)
    else $error("master bit without cause");
  cover property (cmd.clr);
  cover property ($rose(srq));
  cover property (rvalid && rdata == 8'h80);
endmodule // sevr_status_chk

bind sevr_status sevr_status_chk i_chk (.clk(clk), .rstn(rstn), .cmd(cmd),
  .err_evt(err_evt), .mav(mav), .rdata(rdata), .rvalid(rvalid),
  .status_summary_byte(status_summary_byte), .srq(srq));

// ### testbench/sevr_status_tb.sv
`timescale 1ns/100ps
// ****
// status block bench
// ****
module sevr_status_tb;
  import sevr_pkg::*;
  logic       clk, rstn, busy, err_evt, mav, x3, x7, rvalid, srq;
  logic [7:0] rdata, sby;
  sevr_evt_s  evt;
  sevr_cmd_s  cmd;
  int         errors, checks, ese, sre, esr, k;
  sevr_status i_dut (.clk(clk), .rstn(rstn), .cmd(cmd), .evt(evt),
    .busy(busy), .err_evt(err_evt), .mav(mav),
    .first_extra_event_summary(x3), .second_extra_event_summary(x7),
    .rdata(rdata), .rvalid(rvalid), .status_summary_byte(sby), .srq(srq));
  sevr_ctrl_model i_ctl (.clk(clk), .cmd(cmd));
  // 20 MHz clock
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic cmp(input string n, input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // answer stands one cycle only, so look right after the edge
  task automatic q(input sevr_sel_e s, input int e);
    i_ctl.send(4'b0100, s, 8'h00);
    cmp("rvalid", 8'(rvalid), 8'h01);
    cmp(s.name(), rdata, 8'(e));
  endtask
  task automatic w(input sevr_sel_e s, input int v);
    i_ctl.send(4'b1000, s, 8'(v));
  endtask
  // hang guard, far beyond the 132 cycles needed
  initial begin
    #(50 * 2000);
    errors++;
    conclude();
  end
  // main sequence
  initial begin
    {rstn, busy, err_evt, mav, x3, x7} = '0;
    evt = '0;
    void'($urandom(32'h1b86));
    tick(4);
    rstn = 1;
    q(SEVR_SEL_ESE, 0);
    q(SEVR_SEL_SRE, 0);
    q(SEVR_SEL_ESR, 8'h80);
    $display("end reset");
    repeat (4) begin
      ese = $urandom_range(255);
      sre = $urandom_range(255);
      w(SEVR_SEL_ESE, ese);
      w(SEVR_SEL_SRE, sre);
      q(SEVR_SEL_ESE, ese);
      q(SEVR_SEL_SRE, sre & 8'hbc);
    end
    // writes to read-only registers are dropped
    w(SEVR_SEL_ESR, 8'hff);
    q(SEVR_SEL_ESR, 0);
    w(SEVR_SEL_SBY, 8'hff);
    q(SEVR_SEL_SBY, 0);
    $display("end masks");
    // every event line, unused ones included, under a random mask
    for (k = 0; k < 7; k++) begin
      ese = $urandom_range(255);
      w(SEVR_SEL_ESE, ese);
      esr = (2 << k) & 8'hbd;
      evt = sevr_evt_s'(7'(1 << k));
      tick(1);
      evt = '0;
      tick(1);
      cmp("esb", 8'(sby[5]), 8'((esr & ese) != 0));
      q(SEVR_SEL_ESR, esr);
    end
    busy = 1;
    i_ctl.send(4'b0001, SEVR_SEL_ESE, 8'h00);
    tick(3);
    q(SEVR_SEL_ESR, 0);
    busy = 0;
    tick(3);
    q(SEVR_SEL_ESR, 1);
    $display("end events");
    w(SEVR_SEL_ESE, 8'hff);
    w(SEVR_SEL_SRE, 4);
    err_evt = 1;
    evt.cme = 1;
    tick(1);
    err_evt = 0;
    evt = '0;
    tick(3);
    cmp("sby", sby, 8'h64);
    i_ctl.send(4'b0010, SEVR_SEL_ESE, 8'h00);
    tick(2);
    cmp("sby", sby, 8'h00);
    q(SEVR_SEL_ESR, 0);
    $display("end clear");
    w(SEVR_SEL_SRE, 8'hff);
    repeat (3) begin
      {mav, x3, x7} = 3'($urandom);
      tick(2);
      k = {x7, 2'b00, mav, x3, 3'b000};
      if ((k & 8'hbc) != 0) k |= 8'h40;
      cmp("sby", sby, 8'(k));
      q(SEVR_SEL_SBY, k);
    end
    $display("end status byte");
    conclude();
  end
endmodule // sevr_status_tb
